// ---- hdl/pfcs_host.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pfcs_regs.vh"
module pfcs_host #(
  parameter AW        = 17,
  parameter ERASE_TMO = `PFCS_ERASE_TMO_CYC
) (
  input  wire          ref_clk,
  input  wire          rst,
  input  wire          cmd_valid,
  input  wire [1:0]    cmd_op,
  input  wire [AW-1:0] cmd_addr,
  input  wire [7:0]    cmd_data,
  output reg           cmd_ready_reg,
  output reg           rsp_valid_reg,
  output reg  [7:0]    rsp_data_reg,
  output reg           rsp_fail_reg,
  output reg  [AW-1:0] flash_addr_reg,
  output reg  [7:0]    flash_dq_out_reg,
  output reg           flash_dq_oe_n_reg,
  input  wire [7:0]    flash_dq_in,
  output reg           flash_ce_n_reg,
  output reg           flash_oe_n_reg,
  output reg           flash_we_n_reg
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WSET  = 3'h1;
  localparam [2:0] ST_WLOW  = 3'h2;
  localparam [2:0] ST_WHOLD = 3'h3;
  localparam [2:0] ST_RACC  = 3'h4;
  localparam [2:0] ST_GAP   = 3'h5;

  localparam integer SETUP_I = `PFCS_NS2CYC(`PFCS_T_SETUP_NS);
  localparam integer WP_I    = `PFCS_NS2CYC(`PFCS_T_WP_NS);
  localparam integer HOLD_I  = `PFCS_NS2CYC(`PFCS_T_HOLD_NS);
  localparam integer RD_I    = `PFCS_NS2CYC(`PFCS_T_RD_NS);
  localparam integer GAP_I   = `PFCS_NS2CYC(`PFCS_T_GAP_NS);
  localparam integer PTMO_I  = `PFCS_PROG_TMO_CYC;
  localparam integer ETMO_I  = ERASE_TMO;
  localparam integer CONF_I  = `PFCS_CONFIRM_READS;

  // counters are narrower than an integer; the spare upper bits are cut on purpose
  localparam [7:0]  C_SETUP  = SETUP_I[7:0];
  localparam [7:0]  C_WP     = WP_I[7:0];
  localparam [7:0]  C_HOLD   = HOLD_I[7:0];
  localparam [7:0]  C_RD     = RD_I[7:0];
  localparam [7:0]  C_GAP    = GAP_I[7:0];
  localparam [21:0] C_PTMO   = PTMO_I[21:0];
  localparam [21:0] C_ETMO   = ETMO_I[21:0];
  localparam [1:0]  C_CONF   = CONF_I[1:0];

  reg [2:0]    state_reg;
  reg [7:0]    cnt_reg;
  reg [21:0]   tmo_reg;
  reg [1:0]    op_reg;
  reg [2:0]    step_reg;
  reg [AW-1:0] addr_reg;
  reg [7:0]    data_reg;
  reg          polling_reg;
  reg          first_reg;
  reg          prev_alt_reg;
  reg [1:0]    good_reg;

  wire [AW-1:0] unlock1 = {{(AW-16){1'b0}}, `PFCS_UNLOCK1_ADDR};
  wire [AW-1:0] unlock2 = {{(AW-16){1'b0}}, `PFCS_UNLOCK2_ADDR};
  wire [AW-1:0] sector  = {addr_reg[AW-1:`PFCS_SECTOR_LSB], {`PFCS_SECTOR_LSB{1'b0}}};

  // address and data of each guarded cycle; step 3 of a program is the target
  function [AW+7:0] seq_word;
    input [1:0] op;
    input [2:0] step;
    begin
      case (step)
        3'h0: seq_word = {unlock1, `PFCS_UNLOCK1_DATA};
        3'h1: seq_word = {unlock2, `PFCS_UNLOCK2_DATA};
        3'h2: seq_word = {unlock1, (op == `PFCS_OP_PROG) ? `PFCS_CMD_PROG : `PFCS_CMD_ERASE_SET};
        3'h3: seq_word = (op == `PFCS_OP_PROG) ? {addr_reg, data_reg}
                                               : {unlock1, `PFCS_UNLOCK1_DATA};
        3'h4: seq_word = {unlock2, `PFCS_UNLOCK2_DATA};
        3'h5: seq_word = (op == `PFCS_OP_SECTOR) ? {sector, `PFCS_CMD_SECTOR}
                                                 : {unlock1, `PFCS_CMD_CHIP};
        default: seq_word = {unlock1, `PFCS_UNLOCK1_DATA};
      endcase
    end
  endfunction

  wire [2:0]    last_step = (op_reg == `PFCS_OP_PROG) ? 3'h3 : 3'h5;
  wire [AW+7:0] word      = seq_word(op_reg, step_reg);
  // expected polling bit: true data bit after program, one after erase
  wire          exp_poll  = (op_reg == `PFCS_OP_PROG) ? data_reg[`PFCS_POLL_BIT] : 1'b1;
  wire          poll_ok   = (flash_dq_in[`PFCS_POLL_BIT] == exp_poll) &&
                            (flash_dq_in[`PFCS_ALT_BIT] == prev_alt_reg) && !first_reg;
  wire [21:0]   tmo_limit = (op_reg == `PFCS_OP_PROG) ? C_PTMO : C_ETMO;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg         <= ST_IDLE;
      cnt_reg           <= 8'h00;
      tmo_reg           <= 22'h000000;
      op_reg            <= `PFCS_OP_READ;
      step_reg          <= 3'h0;
      addr_reg          <= {AW{1'b0}};
      data_reg          <= 8'h00;
      polling_reg       <= 1'b0;
      first_reg         <= 1'b1;
      prev_alt_reg      <= 1'b0;
      good_reg          <= 2'h0;
      cmd_ready_reg     <= 1'b0;
      rsp_valid_reg     <= 1'b0;
      rsp_data_reg      <= 8'h00;
      rsp_fail_reg      <= 1'b0;
      flash_addr_reg    <= {AW{1'b0}};
      flash_dq_out_reg  <= 8'h00;
      flash_dq_oe_n_reg <= 1'b1;
      flash_ce_n_reg    <= 1'b1;
      flash_oe_n_reg    <= 1'b1;
      flash_we_n_reg    <= 1'b1;
    end
    else
    begin
      rsp_valid_reg <= 1'b0;
      cnt_reg       <= cnt_reg + 8'h01;
      if (polling_reg)
        tmo_reg <= tmo_reg + 22'h000001;
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg        <= 8'h00;
          flash_ce_n_reg <= 1'b1;
          // new commands only once the previous operation reported done
          cmd_ready_reg  <= 1'b1;
          if (cmd_valid && cmd_ready_reg)
          begin
            cmd_ready_reg <= 1'b0;
            op_reg        <= cmd_op;
            addr_reg      <= cmd_addr;
            data_reg      <= cmd_data;
            step_reg      <= 3'h0;
            first_reg     <= 1'b1;
            good_reg      <= 2'h0;
            tmo_reg       <= 22'h000000;
            if (cmd_op == `PFCS_OP_READ)
            begin
              flash_addr_reg <= cmd_addr;
              flash_ce_n_reg <= 1'b0;
              flash_oe_n_reg <= 1'b0;
              state_reg      <= ST_RACC;
            end
            else
              state_reg <= ST_WSET;
          end
        end
        ST_WSET:
        begin
          // gate stays high and the strobe high while address settles
          flash_oe_n_reg    <= 1'b1;
          flash_ce_n_reg    <= 1'b0;
          flash_addr_reg    <= word[AW+7:8];
          flash_dq_out_reg  <= word[7:0];
          flash_dq_oe_n_reg <= 1'b0;
          // a full setup cycle, so the strobe never falls on the edge that moves the address
          if (cnt_reg == C_SETUP)
          begin
            cnt_reg        <= 8'h00;
            flash_we_n_reg <= 1'b0;
            state_reg      <= ST_WLOW;
          end
        end
        ST_WLOW:
        begin
          if (cnt_reg == C_WP - 8'h01)
          begin
            cnt_reg        <= 8'h00;
            flash_we_n_reg <= 1'b1;
            state_reg      <= ST_WHOLD;
          end
        end
        ST_WHOLD:
        begin
          // address and data held past the strobe rise so the latch is clean
          if (cnt_reg == C_HOLD - 8'h01)
          begin
            cnt_reg           <= 8'h00;
            flash_ce_n_reg    <= 1'b1;
            flash_dq_oe_n_reg <= 1'b1;
            state_reg         <= ST_GAP;
            if (step_reg == last_step)
              polling_reg <= 1'b1;
            else
              step_reg <= step_reg + 3'h1;
          end
        end
        ST_GAP:
        begin
          if (cnt_reg == C_GAP - 8'h01)
          begin
            cnt_reg <= 8'h00;
            if (polling_reg)
            begin
              // status read inside what the operation changes, so true data reads back as done
              flash_addr_reg <= (op_reg == `PFCS_OP_PROG)   ? addr_reg :
                                (op_reg == `PFCS_OP_SECTOR) ? sector : unlock1;
              flash_ce_n_reg <= 1'b0;
              flash_oe_n_reg <= 1'b0;
              state_reg      <= ST_RACC;
            end
            else
              state_reg <= ST_WSET;
          end
        end
        ST_RACC:
        begin
          if (cnt_reg == C_RD - 8'h01)
          begin
            cnt_reg        <= 8'h00;
            flash_ce_n_reg <= 1'b1;
            flash_oe_n_reg <= 1'b1;
            if (!polling_reg)
            begin
              rsp_valid_reg <= 1'b1;
              rsp_data_reg  <= flash_dq_in;
              rsp_fail_reg  <= 1'b0;
              state_reg     <= ST_IDLE;
            end
            else
            begin
              first_reg    <= 1'b0;
              prev_alt_reg <= flash_dq_in[`PFCS_ALT_BIT];
              // an apparent finish is only believed after two more clean reads
              if (poll_ok && good_reg == C_CONF)
              begin
                polling_reg   <= 1'b0;
                rsp_valid_reg <= 1'b1;
                rsp_data_reg  <= flash_dq_in;
                rsp_fail_reg  <= 1'b0;
                state_reg     <= ST_IDLE;
              end
              else if (tmo_reg >= tmo_limit)
              begin
                // a stuck flash is left to the user; no abort sequence exists
                polling_reg   <= 1'b0;
                rsp_valid_reg <= 1'b1;
                rsp_data_reg  <= flash_dq_in;
                rsp_fail_reg  <= 1'b1;
                state_reg     <= ST_IDLE;
              end
              else
              begin
                good_reg  <= poll_ok ? good_reg + 2'h1 : 2'h0;
                state_reg <= ST_GAP;
              end
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pfcs_host
`default_nettype wire

// ---- hdl/pfcs_regs.vh ----
`ifndef PFCS_REGS_VH
`define PFCS_REGS_VH
`define PFCS_CLK_MHZ        20
`define PFCS_NS2CYC(ns)     ((((ns) * `PFCS_CLK_MHZ) + 999) / 1000)
`define PFCS_T_SETUP_NS     50
`define PFCS_T_WP_NS        100
`define PFCS_T_HOLD_NS      50
`define PFCS_T_RD_NS        100
`define PFCS_T_GAP_NS       50
`define PFCS_PROG_MAX_US    30
`define PFCS_PROG_TMO_CYC   (`PFCS_PROG_MAX_US * `PFCS_CLK_MHZ)
`define PFCS_ERASE_MAX_MS   100
`define PFCS_ERASE_TMO_CYC  (`PFCS_ERASE_MAX_MS * 1000 * `PFCS_CLK_MHZ)
`define PFCS_CONFIRM_READS  2
`define PFCS_UNLOCK1_ADDR   16'h5555
`define PFCS_UNLOCK2_ADDR   16'h2AAA
`define PFCS_UNLOCK1_DATA   8'hAA
`define PFCS_UNLOCK2_DATA   8'h55
`define PFCS_CMD_PROG       8'hA0
`define PFCS_CMD_ERASE_SET  8'h80
`define PFCS_CMD_SECTOR     8'h30
`define PFCS_CMD_CHIP       8'h10
`define PFCS_SECTOR_LSB     12
`define PFCS_OP_READ        2'h0
`define PFCS_OP_PROG        2'h1
`define PFCS_OP_SECTOR      2'h2
`define PFCS_OP_CHIP        2'h3
`define PFCS_POLL_BIT       7
`define PFCS_ALT_BIT        6
`endif

// ---- sim/pfcs_host_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfcs_host_props #(
  parameter AW = 17
) (
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          cmd_valid,
  input wire logic [1:0]    cmd_op,
  input wire logic          cmd_ready_reg,
  input wire logic          rsp_valid_reg,
  input wire logic [AW-1:0] flash_addr_reg,
  input wire logic [7:0]    flash_dq_out_reg,
  input wire logic          flash_dq_oe_n_reg,
  input wire logic          flash_ce_n_reg,
  input wire logic          flash_oe_n_reg,
  input wire logic          flash_we_n_reg
);
  logic [1:0] op_reg;
  logic [2:0] wn_reg;
  logic       we_q_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // counts finished write cycles of the current request
  always @(posedge ref_clk)
  begin
    we_q_reg <= flash_we_n_reg;
    if (rst || (cmd_valid && cmd_ready_reg))
    begin
      wn_reg <= 3'h0;
      op_reg <= cmd_op;
    end
    else if (flash_we_n_reg && !we_q_reg)
      wn_reg <= wn_reg + 3'h1;
  end
  AST_WE_WITH_CE: assert property (!flash_we_n_reg |-> !flash_ce_n_reg)
    else $error("strobe low without select");
  AST_WE_GATE_HIGH: assert property (!flash_we_n_reg |-> flash_oe_n_reg)
    else $error("strobe low with gate low");
  AST_DQ_NO_CLASH: assert property (!flash_dq_oe_n_reg |-> flash_oe_n_reg)
    else $error("host drives data while gate low");
  AST_WE_WIDTH: assert property ($fell(flash_we_n_reg) |=> !flash_we_n_reg ##1 flash_we_n_reg)
    else $error("strobe pulse width wrong");
  AST_DATA_HELD: assert property (!flash_we_n_reg |->
    $stable(flash_addr_reg) && $stable(flash_dq_out_reg) && !flash_dq_oe_n_reg)
    else $error("address or data moved under strobe");
  AST_UNLOCK_AA: assert property ($fell(flash_we_n_reg) && (wn_reg == 3'h0 || wn_reg == 3'h3
    && op_reg != 2'h1) |-> flash_addr_reg == 17'h05555 && flash_dq_out_reg == 8'hAA)
    else $error("first unlock cycle wrong");
  AST_UNLOCK_55: assert property ($fell(flash_we_n_reg) && (wn_reg == 3'h1 || wn_reg == 3'h4)
    |-> flash_addr_reg == 17'h02AAA && flash_dq_out_reg == 8'h55)
    else $error("second unlock cycle wrong");
  AST_SETUP_CMD: assert property ($fell(flash_we_n_reg) && wn_reg == 3'h2 |->
    flash_dq_out_reg == (op_reg == 2'h1 ? 8'hA0 : 8'h80))
    else $error("setup command wrong");
  AST_LAST_CMD: assert property ($fell(flash_we_n_reg) && wn_reg == 3'h5 |->
    flash_dq_out_reg == (op_reg == 2'h3 ? 8'h10 : 8'h30)
    && (op_reg != 2'h3 || flash_addr_reg == 17'h05555))
    else $error("erase command wrong");
  AST_CYCLE_COUNT: assert property (rsp_valid_reg |->
    wn_reg == (op_reg == 2'h0 ? 3'h0 : op_reg == 2'h1 ? 3'h4 : 3'h6))
    else $error("write cycle count wrong");
  AST_READ_TIME: assert property (cmd_valid && cmd_ready_reg && cmd_op == 2'h0 |->
    ##[3:4] rsp_valid_reg)
    else $error("read answer late");
endmodule // pfcs_host_props
bind pfcs_host pfcs_host_props #(.AW(AW)) u_props (.ref_clk(ref_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready_reg(cmd_ready_reg),
  .rsp_valid_reg(rsp_valid_reg), .flash_addr_reg(flash_addr_reg),
  .flash_dq_out_reg(flash_dq_out_reg), .flash_dq_oe_n_reg(flash_dq_oe_n_reg),
  .flash_ce_n_reg(flash_ce_n_reg), .flash_oe_n_reg(flash_oe_n_reg),
  .flash_we_n_reg(flash_we_n_reg));
`default_nettype wire

// ---- sim/pfcs_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfcs_flash_model (
  input wire logic        ref_clk,
  input wire logic        slow,
  input wire logic [16:0] addr,
  input wire logic [7:0]  din,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  output logic [7:0]      dq
);
  logic [7:0]  mem [0:131071];
  logic [16:0] la;
  logic [7:0]  pat = 8'hA5;
  logic [7:0]  pd = 8'h00;
  logic        tog = 1'b0;
  logic        era = 1'b0;
  int          busy = 0;
  int          st = 0;
  wire         wr = ce_n | we_n;
  wire         rd = ce_n | oe_n;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // busy time counted in host clocks only to keep the model short
  always @(posedge ref_clk)
  begin
    pat <= ~pat;
    // non-blocking so the host never races the busy-to-ready change on its own edge
    if (busy > 0)
      busy <= busy - 1;
  end
  always @(negedge wr) la = addr;
  always @(posedge rd) tog = ~tog;
  always @(posedge wr)
    if (oe_n && busy == 0)
    begin
      st = st + 1;
      case (st)
        1, 4: if (din !== 8'hAA) st = 0;
        2, 5: if (din !== 8'h55) st = 0;
        3: st = din == 8'hA0 ? 10 : din == 8'h80 ? 3 : 0;
        6: if (din !== 8'h30 && din !== 8'h10) st = 0;
        default: ;
      endcase
      if (st == 6 || st == 11)
      begin
        era = st == 6;
        pd = din;
        if (st == 11)
          mem[la] = mem[la] & din;
        else
          for (int i = 0; i < 131072; i++)
            if (din == 8'h10 || i[16:12] == la[16:12]) mem[i] = 8'hFF;
        busy = slow ? 700 : 40;
        tog = 1'b1;
        st = 0;
      end
    end
  // released bus shows a changing pattern, never the last value
  assign dq = rd ? pat : busy > 0 ? {era ? 1'b0 : ~pd[7], tog, 6'h00}
    : mem[addr];
endmodule // pfcs_flash_model
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb;
  typedef struct {logic [1:0] op; logic [16:0] a; logic [7:0] d; logic [7:0] e;} pfcs_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op = 2'h0;
  logic [16:0] cmd_addr = 17'h00000;
  logic [7:0]  cmd_data = 8'h00;
  logic        slow = 1'b0;
  wire         ready, rsp_valid, rsp_fail, dq_oe_n, ce_n, oe_n, we_n;
  wire  [7:0]  rsp_data, dq_out, dq_in;
  wire  [16:0] faddr;
  int          err_total = 0;
  int          total_checks = 0;
  logic [7:0]  rd;
  logic        fl;
  pfcs_row_t   rows [8] = '{'{2'h1, 17'h00123, 8'h3C, 8'h3C}, '{2'h0, 17'h00123, 8'h00, 8'h3C},
    '{2'h1, 17'h01000, 8'hC3, 8'hC3}, '{2'h2, 17'h00ABC, 8'h00, 8'hFF},
    '{2'h0, 17'h00123, 8'h00, 8'hFF}, '{2'h0, 17'h01000, 8'h00, 8'hC3},
    '{2'h3, 17'h00000, 8'h00, 8'hFF}, '{2'h0, 17'h01000, 8'h00, 8'hFF}};
  always #25 ref_clk = ~ref_clk;
  pfcs_host #(.AW(17), .ERASE_TMO(2000)) dut (.ref_clk(ref_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_ready_reg(ready), .rsp_valid_reg(rsp_valid), .rsp_data_reg(rsp_data),
    .rsp_fail_reg(rsp_fail), .flash_addr_reg(faddr), .flash_dq_out_reg(dq_out),
    .flash_dq_oe_n_reg(dq_oe_n), .flash_dq_in(dq_in), .flash_ce_n_reg(ce_n),
    .flash_oe_n_reg(oe_n), .flash_we_n_reg(we_n));
  pfcs_flash_model u_flash (.ref_clk(ref_clk), .slow(slow), .addr(faddr), .din(dq_out),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq_in));
  task automatic run(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1) @(posedge ref_clk) #1;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
    // a response that never comes must not pass on stale data
    if (n >= 20000)
      err_total++;
    rd = rsp_data;
    fl = rsp_fail;
  endtask
  task final_report;
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    `CHK({ce_n, oe_n, we_n, dq_oe_n, ready}, 5'h1E)
    foreach (rows[i])
    begin
      run(rows[i].op, rows[i].a, rows[i].d);
      `CHK({fl, rd}, {1'b0, rows[i].e})
    end
    // slow part outlasts the program timeout, then a read lands while still busy
    slow <= 1'b1;
    run(2'h1, 17'h02000, 8'h81);
    `CHK(fl, 1'b1)
    run(2'h0, 17'h02000, 8'h00);
    `CHK({rd[7], rd[5:0]}, 7'h00)
    final_report();
  end
  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule // tb
`default_nettype wire
